//--- src/iof_params.svh
// constants for the intelligent output flag block
`ifndef IOF_PARAMS_SVH
`define IOF_PARAMS_SVH

// -----------------------------------------------------------------------------
// output function codes
// -----------------------------------------------------------------------------
`define IOF_CODE_COMBINE 8'h09
`define IOF_CODE_FB_LOSS 8'h0a
`define IOF_CODE_LOW_CUR 8'h2b

// -----------------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------------
`define IOF_ADDR_CTRL 4'h0
`define IOF_ADDR_TIMEOUT 4'h1
`define IOF_ADDR_THRESH 4'h2
`define IOF_ADDR_STATUS 4'h3
`define IOF_ADDR_IRQ_STAT 4'h4
`define IOF_ADDR_IRQ_MASK 4'h5
`define IOF_ADDR_CURRENT 4'h6

// -----------------------------------------------------------------------------
// control field positions
// -----------------------------------------------------------------------------
`define IOF_CTRL_OPA_LSB 0
`define IOF_CTRL_OPB_LSB 4
`define IOF_CTRL_OPR_LSB 8
`define IOF_CTRL_RESP_LSB 12
`define IOF_CTRL_LCMODE_BIT 16

// -----------------------------------------------------------------------------
// reset values and timing
// -----------------------------------------------------------------------------
`define IOF_CTRL_RESET 32'h0000_0000
`define IOF_TIMEOUT_RESET 16'h0000
`define IOF_THRESH_RESET 16'h0000
`define IOF_TICK_US 10000
`define IOF_CLK_MHZ 25
`define IOF_TICK_CYCLES (`IOF_TICK_US * `IOF_CLK_MHZ)

`endif

//--- src/iof_pkg.sv
// types for the intelligent output flag block
package iof_pkg;

  typedef enum logic [1:0]
  {
    IOF_OP_AND,
    IOF_OP_OR,
    IOF_OP_XOR,
    IOF_OP_RSVD
  } iof_op_e;

  typedef struct packed
  {
    logic combine;
    logic fb_loss;
    logic low_cur;
  } iof_flags_s;

  typedef enum logic
  {
    IOF_WD_IDLE,
    IOF_WD_RUN
  } iof_wd_e;

endpackage

//--- src/iof_top.sv
// intelligent output flags: combiner, fieldbus loss, low load
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "iof_params.svh"

module iof_top
  import iof_pkg::*;
#(
  parameter int TICK_CYCLES = `IOF_TICK_CYCLES,
  parameter int CW = 16,
  parameter int NSRC = 9
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic [NSRC-1:0] source_flags,
  input wire logic fieldbus_activity,
  input wire logic [CW-1:0] output_current,
  output logic combine_flag,
  output logic fieldbus_loss_flag,
  output logic low_current_flag,
  output logic irq
);

  // -----------------------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d;
  logic [15:0] timeout_q, timeout_d;
  logic [CW-1:0] thresh_q, thresh_d;
  logic [2:0] stat_q, stat_d;
  logic [2:0] mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  iof_flags_s flags_q, flags_d;
  logic wd_loss;

  logic [3:0] first_operand_select;
  logic [3:0] second_operand_select;
  iof_op_e combine_operator_select;
  logic [1:0] fieldbus_loss_response;
  logic low_current_mode;
  logic opa, opb, comb_res;
  logic [2:0] rise;

  assign first_operand_select = ctrl_q[`IOF_CTRL_OPA_LSB +: 4];
  assign second_operand_select = ctrl_q[`IOF_CTRL_OPB_LSB +: 4];
  assign combine_operator_select = iof_op_e'(ctrl_q[`IOF_CTRL_OPR_LSB +: 2]);
  // response code decoded but unused; this block has no trip logic and only reads it back through the control register
  assign fieldbus_loss_response = ctrl_q[`IOF_CTRL_RESP_LSB +: 2];
  assign low_current_mode = ctrl_q[`IOF_CTRL_LCMODE_BIT];

  // -----------------------------------------------------------------------------
  // fieldbus watchdog
  // -----------------------------------------------------------------------------
  iof_watchdog #(
    .TICK_CYCLES(TICK_CYCLES),
    .TW(16)
  ) u_wd (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .activity(fieldbus_activity),
    .period(timeout_q),
    .loss(wd_loss)
  );

  // -----------------------------------------------------------------------------
  // flag logic
  // -----------------------------------------------------------------------------
  always_comb
  begin
    // out-of-range selects read as zero
    opa = (first_operand_select < NSRC) ? source_flags[first_operand_select] : 1'b0;
    opb = (second_operand_select < NSRC) ? source_flags[second_operand_select] : 1'b0;
    case (combine_operator_select)
      IOF_OP_AND: comb_res = opa & opb;
      IOF_OP_OR: comb_res = opa | opb;
      IOF_OP_XOR: comb_res = opa ^ opb;
      default: comb_res = 1'b0;
    endcase
    flags_d = flags_q;
    flags_d.combine = comb_res;
    flags_d.fb_loss = wd_loss;
    // mode bit gates the comparator; off holds flag low
    if (!low_current_mode)
      flags_d.low_cur = 1'b0;
    else if (output_current < thresh_q)
      flags_d.low_cur = 1'b1;
    else if (output_current > thresh_q)
      flags_d.low_cur = 1'b0;
    else
      flags_d.low_cur = flags_q.low_cur;
  end

  // -----------------------------------------------------------------------------
  // register bus and interrupt
  // -----------------------------------------------------------------------------
  always_comb
  begin
    ctrl_d = ctrl_q;
    timeout_d = timeout_q;
    thresh_d = thresh_q;
    mask_d = mask_q;
    rise = {flags_d.low_cur & ~flags_q.low_cur,
            flags_d.fb_loss & ~flags_q.fb_loss,
            flags_d.combine & ~flags_q.combine};
    stat_d = stat_q;
    rdata_d = 32'h0;
    if (wr_en)
    begin
      case (addr)
        `IOF_ADDR_CTRL: ctrl_d = wdata;
        `IOF_ADDR_TIMEOUT: timeout_d = wdata[15:0];
        `IOF_ADDR_THRESH: thresh_d = wdata[CW-1:0];
        `IOF_ADDR_IRQ_MASK: mask_d = wdata[2:0];
        default: ;
      endcase
    end
    if (rd_en)
    begin
      case (addr)
        `IOF_ADDR_CTRL: rdata_d = ctrl_q;
        `IOF_ADDR_TIMEOUT: rdata_d = {16'h0, timeout_q};
        `IOF_ADDR_THRESH: rdata_d = 32'(thresh_q);
        `IOF_ADDR_STATUS: rdata_d = {29'h0, flags_q};
        `IOF_ADDR_IRQ_STAT:
        begin
          rdata_d = {29'h0, stat_q};
          stat_d = 3'h0;
        end
        `IOF_ADDR_IRQ_MASK: rdata_d = {29'h0, mask_q};
        `IOF_ADDR_CURRENT: rdata_d = 32'(output_current);
        default: rdata_d = 32'h0;
      endcase
    end
    // set wins over the read clear
    stat_d = stat_d | rise;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q <= `IOF_CTRL_RESET;
      timeout_q <= `IOF_TIMEOUT_RESET;
      thresh_q <= CW'(`IOF_THRESH_RESET);
      stat_q <= 3'h0;
      mask_q <= 3'h0;
      rdata_q <= 32'h0;
      irq_q <= 1'b0;
      flags_q <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      timeout_q <= timeout_d;
      thresh_q <= thresh_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      flags_q <= flags_d;
    end
  end

  assign rdata = rdata_q;
  assign combine_flag = flags_q.combine;
  assign fieldbus_loss_flag = flags_q.fb_loss;
  assign low_current_flag = flags_q.low_cur;
  assign irq = irq_q;

endmodule

//--- src/iof_watchdog.sv
// fieldbus silence watchdog with 10 ms tick prescaler
`timescale 1ns/1ps
`include "iof_params.svh"

module iof_watchdog
  import iof_pkg::*;
#(
  parameter int TICK_CYCLES = `IOF_TICK_CYCLES,
  parameter int TW = 16
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic activity,
  input wire logic [TW-1:0] period,
  output logic loss
);

  logic [31:0] pre_q, pre_d;
  logic [TW-1:0] cnt_q, cnt_d;
  logic loss_q, loss_d;
  logic tick;

  // -----------------------------------------------------------------------------
  // prescaler and silence counter
  // -----------------------------------------------------------------------------
  always_comb
  begin
    tick = (pre_q == 32'(TICK_CYCLES - 1));
    pre_d = tick ? 32'h0 : pre_q + 32'h1;
    cnt_d = cnt_q;
    loss_d = loss_q;
    if (period == '0)
    begin
      // zero period disables the watchdog
      cnt_d = '0;
      loss_d = 1'b0;
    end
    else if (activity)
    begin
      cnt_d = '0;
      loss_d = 1'b0;
    end
    else if (tick)
    begin
      if (cnt_q >= period)
        loss_d = 1'b1;
      else
        cnt_d = cnt_q + 1'b1;
    end
    if (activity)
      pre_d = 32'h0;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_q <= 32'h0;
      cnt_q <= '0;
      loss_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      loss_q <= loss_d;
    end
  end

  assign loss = loss_q;

endmodule

//--- tb/intelligent_output_flags_test.sv
// self-checking bench of the intelligent output flag block
`timescale 1ns/1ps
module intelligent_output_flags_test
  import iof_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [8:0] source_flags = 9'h0;
  logic [15:0] output_current = 16'h0;
  logic quiet = 1'b0;
  logic [31:0] rdata, v, ctl;
  logic [31:0] seed = 32'h1b42b6cf;
  logic combine_flag, fieldbus_loss_flag, low_current_flag, irq, fieldbus_activity;
  logic [15:0] th;
  logic [15:0] dl[5] = '{16'hffff, 16'h0, 16'h1, 16'h0, 16'hffff};
  logic [4:0] ex = 5'b10011;
  int fail_count = 0;
  int n_compared = 0;
  int n;
  iof_top #(.TICK_CYCLES(4)) DUT (.ref_clk, .reset_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .source_flags,
    .fieldbus_activity, .output_current, .combine_flag, .fieldbus_loss_flag, .low_current_flag, .irq);
  iof_far_side far (.ref_clk, .quiet, .gap(8'h5), .fieldbus_activity);
  initial forever #20 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic comb_exp(input logic [31:0] c, input logic [8:0] f);
    logic a;
    logic b;
    a = c[3:0] < 4'h9 ? f[c[3:0]] : 1'b0;
    b = c[7:4] < 4'h9 ? f[c[7:4]] : 1'b0;
    return c[9:8] == 2'h0 ? a & b : c[9:8] == 2'h1 ? a | b : c[9:8] == 2'h2 ? a ^ b : 1'b0;
  endfunction
  task automatic complete_run;
    if (fail_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // bounded wait; running out ends the run as a failure
  task automatic wait_loss(input logic lvl, output int n);
    n = 0;
    while (fieldbus_loss_flag !== lvl)
    begin
      tick(1);
      n++;
      if (n > 99)
      begin
        fail_count++;
        complete_run;
      end
    end
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 9; a++)
    begin
      rd(a[3:0], v);
      check("reset reg", v, 32'h0);
    end
    for (int k = 0; k < 48; k++)
    begin
      seed = xs(seed);
      if (k % 8 == 0)
      begin
        ctl = {22'h0, k[4:3], seed[7:0]};
        wr(4'h0, ctl);
      end
      @(posedge ref_clk);
      source_flags <= seed[8:0];
      tick(1);
      check("combine", combine_flag, comb_exp(ctl, seed[8:0]));
    end
    th = {1'b0, seed[14:1], 1'b1};
    wr(4'h2, {16'h0, th});
    wr(4'h0, 32'h0001_0000);
    for (int k = 0; k < 5; k++)
    begin
      @(posedge ref_clk);
      output_current <= th + dl[k];
      tick(1);
      check("low load", low_current_flag, ex[k]);
    end
    wr(4'h5, 32'h2);
    wr(4'h1, 32'h3);
    rd(4'h1, v);
    check("timeout reg", v, 32'h3);
    rd(4'h2, v);
    check("thresh reg", v, {16'h0, th});
    rd(4'h5, v);
    check("mask reg", v, 32'h2);
    rd(4'h6, v);
    check("current reg", v, {16'h0, th - 16'h1});
    rd(4'h4, v);
    for (int k = 0; k < 30; k++)
    begin
      tick(1);
      check("loss idle", fieldbus_loss_flag, 1'b0);
    end
    quiet <= 1'b1;
    wait_loss(1'b1, n);
    check("silence", n > 6 && n < 24, 1'b1);
    tick(2);
    check("irq set", irq, 1'b1);
    wr(4'h5, 32'h0);
    tick(1);
    check("irq masked", irq, 1'b0);
    wr(4'h5, 32'h2);
    tick(1);
    check("irq unmasked", irq, 1'b1);
    rd(4'h4, v);
    check("irq status", v, 32'h2);
    tick(1);
    check("irq cleared", irq, 1'b0);
    quiet <= 1'b0;
    wait_loss(1'b0, n);
    check("loss clear", n < 9, 1'b1);
    complete_run;
  end
endmodule

//--- tb/iof_far_side.sv
// option module model: one activity pulse every gap+1 cycles
`timescale 1ns/1ps
module iof_far_side
(
  input wire logic ref_clk,
  input wire logic quiet,
  input wire logic [7:0] gap,
  output logic fieldbus_activity
);
  logic [7:0] cnt_q = 8'h0;
  logic [7:0] cnt_d;
  always_comb
  begin
    cnt_d = (cnt_q >= gap) ? 8'h0 : cnt_q + 8'h1;
  end
  always_ff @(posedge ref_clk)
  begin
    cnt_q <= cnt_d;
  end
  assign fieldbus_activity = !quiet && cnt_q == 8'h0;
endmodule

//--- tb/iof_top_checker.sv
// assertions on the ports of the intelligent output flag block
`timescale 1ns/1ps
module iof_top_checker
  import iof_pkg::*;
#(
  parameter int TICK_CYCLES = 4,
  parameter int CW = 16,
  parameter int NSRC = 9
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic [NSRC-1:0] source_flags,
  input wire logic fieldbus_activity,
  input wire logic [CW-1:0] output_current,
  input wire logic combine_flag,
  input wire logic fieldbus_loss_flag,
  input wire logic low_current_flag
);
  logic [16:0] ctl_q, ctl_d;
  logic [15:0] to_q, to_d;
  logic [CW-1:0] th_q, th_d;
  logic [19:0] sil_q, sil_d;
  logic sa, sb;
  assign sa = ctl_q[3:0] < NSRC ? source_flags[ctl_q[3:0]] : 1'b0;
  assign sb = ctl_q[7:4] < NSRC ? source_flags[ctl_q[7:4]] : 1'b0;
  always_comb
  begin
    ctl_d = (wr_en && addr == 4'h0) ? wdata[16:0] : ctl_q;
    to_d = (wr_en && addr == 4'h1) ? wdata[15:0] : to_q;
    th_d = (wr_en && addr == 4'h2) ? wdata[CW-1:0] : th_q;
    // saturates so a long silence never wraps to zero
    sil_d = fieldbus_activity ? 20'h0 : sil_q + {19'h0, ~&sil_q};
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      {ctl_q, to_q, th_q, sil_q} <= '0;
    else
      {ctl_q, to_q, th_q, sil_q} <= {ctl_d, to_d, th_d, sil_d};
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  a_first_operand: assert property (ctl_q[9:8] == 2'h1 && !sb |=> combine_flag == $past(sa))
    else $error("combine ignores first operand");
  a_xor_operator: assert property (ctl_q[9:8] == 2'h2 |=> combine_flag == $past(sa ^ sb))
    else $error("combine xor wrong");
  a_and_result: assert property (ctl_q[9:8] == 2'h0 |=> combine_flag == $past(sa & sb))
    else $error("combine and wrong");
  // generous bound: tick phase plus two register stages
  a_loss_sets: assert property (to_q != 0 && sil_q > (to_q + 2) * TICK_CYCLES + 3 |-> fieldbus_loss_flag)
    else $error("loss flag missing after silence");
  a_loss_clears: assert property (fieldbus_activity |-> ##2 !fieldbus_loss_flag)
    else $error("loss flag kept despite activity");
  a_low_below: assert property (ctl_q[16] && output_current < th_q |=> low_current_flag)
    else $error("low flag missing");
  a_low_above: assert property (output_current > th_q |=> !low_current_flag)
    else $error("low flag above threshold");
  a_low_equal_hold: assert property (ctl_q[16] && output_current == th_q |=> $stable(low_current_flag))
    else $error("low flag moved on equality");
  cover property (ctl_q[9:8] == 2'h2 ##1 combine_flag);
  cover property ($rose(fieldbus_loss_flag));
  cover property ($rose(low_current_flag));
endmodule

bind iof_top iof_top_checker #(.TICK_CYCLES(TICK_CYCLES), .CW(CW), .NSRC(NSRC)) chk (.ref_clk, .reset_n,
  .addr, .wdata, .wr_en, .source_flags, .fieldbus_activity, .output_current, .combine_flag,
  .fieldbus_loss_flag, .low_current_flag);
